// [pkg/ddcnc_pkg.sv]
/*
  ddcnc_pkg: register indices, field positions, reset
  values and decimation codes of the downconverter
  channel 0 configuration block.
  Assumes a 32-bit classic Wishbone bus whose byte address
  is four times the register index.
*/
package ddcnc_pkg;
  // register indices; byte address = index * 4
  localparam logic [9:0] IDX_CTRL    = 10'h310;
  localparam logic [9:0] IDX_ROUTE   = 10'h311;
  localparam logic [9:0] IDX_FREQ0   = 10'h314;
  localparam logic [9:0] IDX_FREQ1   = 10'h315;
  localparam logic [9:0] IDX_FREQ2   = 10'h316;
  localparam logic [9:0] IDX_FREQ3   = 10'h317;
  localparam logic [9:0] IDX_FREQ4   = 10'h318;
  localparam logic [9:0] IDX_FREQ5   = 10'h31a;
  localparam logic [9:0] IDX_PHASE0  = 10'h31d;
  localparam logic [9:0] IDX_STATUS  = 10'h3f0;
  localparam logic [9:0] IDX_ACCTOP  = 10'h3f1;
  localparam int         ADR_W       = 12;
  localparam int         IDX_LSB     = 2;

  // control register fields
  localparam int         CTRL_GAIN   = 6;
  localparam int         CTRL_C2R    = 3;
  localparam int         CTRL_DEC_HI = 1;
  localparam int         CTRL_DEC_LO = 0;
  // routing register fields
  localparam int         ROUTE_Q     = 2;
  localparam int         ROUTE_I     = 0;

  // widths and reset values
  localparam int         FREQ_W      = 48;
  localparam int         BYTE_W      = 8;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [47:0] RST_WORD   = 48'h0;

  // decimation codes
  localparam logic [1:0] DEC_DIV2    = 2'h3;
  localparam logic [1:0] DEC_DIV4    = 2'h0;
  localparam logic [1:0] DEC_DIV8    = 2'h1;
  localparam logic [1:0] DEC_DIV16   = 2'h2;

  // stage enable patterns, bit 0 = final stage
  localparam logic [3:0] STG_FINAL   = 4'h1;
  localparam logic [3:0] STG_TWO     = 4'h3;
  localparam logic [3:0] STG_THREE   = 4'h7;
  localparam logic [3:0] STG_ALL     = 4'hf;

  // fs/4 rotation phases for complex-to-real
  typedef enum logic [1:0] {
    ROT_P_I = 2'b00,
    ROT_N_Q = 2'b01,
    ROT_N_I = 2'b10,
    ROT_P_Q = 2'b11
  } ddcnc_rot_t;
endpackage

// [design/ddcnc_dec_map.sv]
/*
  ddcnc_dec_map: turns the two-bit decimation code and the
  complex-to-real flag into half-band stage enables and
  the log2 of the overall ratio.
  Assumes registered inputs; purely combinational.
*/
`timescale 1ns/1ps
module ddcnc_dec_map
  import ddcnc_pkg::*;
(
  input  wire logic [1:0] code_i,       // decimation code
  input  wire logic       c2r_i,        // complex-to-real on
  output logic      [3:0] stage_en_o,   // stage enables
  output logic      [2:0] ratio_log2_o  // log2 of ratio
);
  logic [2:0] cplx_log2;

  // cumulative stages; c2r halves the ratio
  always_comb begin
    case (code_i)
      DEC_DIV2: begin
        stage_en_o = STG_FINAL;
        cplx_log2  = 3'h1;
      end
      DEC_DIV4: begin
        stage_en_o = STG_TWO;
        cplx_log2  = 3'h2;
      end
      DEC_DIV8: begin
        stage_en_o = STG_THREE;
        cplx_log2  = 3'h3;
      end
      default: begin
        stage_en_o = STG_ALL;
        cplx_log2  = 3'h4;
      end
    endcase
    ratio_log2_o = c2r_i ? 3'(cplx_log2 - 3'h1) : cplx_log2;
  end
endmodule

// [design/ddcnc_top.sv]
/*
  ddcnc_top: configuration registers of downconverter
  channel 0 with input routing, oscillator accumulator,
  decimation selection, gain and complex-to-real output.
  Assumes a classic Wishbone master on the same clock and
  filtered samples from same-clock logic.
*/
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
// Function
// - complex mode codes give ratios 2,4,8,16
// - real mode codes give ratios 1,2,4,8
// - each code enables cumulative half-band stages
// - route bit 2 picks Q source A/B
// - route bit 0 picks I source; rest reserved
// - six byte registers assemble the frequency word
// - accumulator wraps modulo 2^48 per tone
// - offset byte adds to oscillator phase
// - real mode outputs I only, fs/4 mixed
// - gain bit doubles the output
module ddcnc_top
  import ddcnc_pkg::*;
#(
  parameter int SMP_W = 16  // sample width
) (
  input  wire logic             CLK_I,       // 10 MHz clock
  input  wire logic             RST_I,       // sync reset, high
  input  wire logic             CYC_I,       // bus cycle
  input  wire logic             STB_I,       // bus strobe
  input  wire logic             WE_I,        // write enable
  input  wire logic [ADR_W-1:0] ADR_I,       // byte address
  input  wire logic [3:0]       SEL_I,       // byte lanes
  input  wire logic [31:0]      DAT_I,       // write data
  output logic      [31:0]      DAT_O,       // read data
  output logic                  ACK_O,       // bus acknowledge
  input  wire logic [SMP_W-1:0] ADC_A_I,     // channel A sample
  input  wire logic [SMP_W-1:0] ADC_B_I,     // channel B sample
  output logic      [SMP_W-1:0] SRC_I_O,     // routed I sample
  output logic      [SMP_W-1:0] SRC_Q_O,     // routed Q sample
  input  wire logic [SMP_W-1:0] FILT_I_I,    // filtered I
  input  wire logic [SMP_W-1:0] FILT_Q_I,    // filtered Q
  output logic      [SMP_W-1:0] OUT_I_O,     // output I / real
  output logic      [SMP_W-1:0] OUT_Q_O,     // output Q
  output logic      [FREQ_W-1:0] PHASE_O,    // oscillator phase
  output logic      [3:0]       STAGE_EN_O,  // half-band enables
  output logic      [2:0]       DEC_LOG2_O,  // log2 of ratio
  output logic                  C2R_O        // real output mode
);
  typedef struct packed {
    logic [1:0]        dec;
    logic              c2r;
    logic              gain;
    logic              i_sel;
    logic              q_sel;
    logic [FREQ_W-1:0] freq;
    logic [BYTE_W-1:0] phs;
    logic [FREQ_W-1:0] acc;
    logic [FREQ_W-1:0] phase;
    ddcnc_rot_t        rot;
    logic [3:0]        stage;
    logic [2:0]        log2;
    logic              ack;
    logic [BYTE_W-1:0] dat;
    logic [SMP_W-1:0]  src_i;
    logic [SMP_W-1:0]  src_q;
    logic [SMP_W-1:0]  out_i;
    logic [SMP_W-1:0]  out_q;
  } ddcnc_state_t;

  ddcnc_state_t r;
  ddcnc_state_t next_r;
  logic [9:0]   idx;
  logic         req;
  logic         wr;
  logic [7:0]   wdat;
  logic [3:0]   map_stage;
  logic [2:0]   map_log2;
  logic [7:0]   rd_byte;
  logic [SMP_W-1:0] gi;
  logic [SMP_W-1:0] gq;

  assign idx  = ADR_I[ADR_W-1:IDX_LSB];
  assign req  = CYC_I & STB_I;
  // write lands on the edge the master sees ack
  assign wr   = req & WE_I & r.ack & SEL_I[0];
  assign wdat = DAT_I[7:0];

  ddcnc_dec_map u_map (
    .code_i       (r.dec),
    .c2r_i        (r.c2r),
    .stage_en_o   (map_stage),
    .ratio_log2_o (map_log2)
  );

  // read mux; reserved bits and unmapped space read zero
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_CTRL: begin
        rd_byte[CTRL_GAIN] = r.gain;
        rd_byte[CTRL_C2R]  = r.c2r;
        rd_byte[CTRL_DEC_HI:CTRL_DEC_LO] = r.dec;
      end
      IDX_ROUTE: begin
        rd_byte[ROUTE_Q] = r.q_sel;
        rd_byte[ROUTE_I] = r.i_sel;
      end
      IDX_FREQ0:  rd_byte = r.freq[7:0];
      IDX_FREQ1:  rd_byte = r.freq[15:8];
      IDX_FREQ2:  rd_byte = r.freq[23:16];
      IDX_FREQ3:  rd_byte = r.freq[31:24];
      IDX_FREQ4:  rd_byte = r.freq[39:32];
      IDX_FREQ5:  rd_byte = r.freq[47:40];
      IDX_PHASE0: rd_byte = r.phs;
      IDX_STATUS: rd_byte = {1'b0, r.log2, r.stage};
      IDX_ACCTOP: rd_byte = r.acc[47:40];
      default:    rd_byte = 8'h00;
    endcase
  end

  // gain stage; shift drops the top bit, caller's headroom
  assign gi = r.gain ? {FILT_I_I[SMP_W-2:0], 1'b0} : FILT_I_I;
  assign gq = r.gain ? {FILT_Q_I[SMP_W-2:0], 1'b0} : FILT_Q_I;

  // next state
  always_comb begin
    next_r = r;
    // single-cycle ack, one wait state before it
    next_r.ack = req & ~r.ack;
    if (req & ~r.ack) begin
      next_r.dat = rd_byte;
    end
    if (wr) begin
      case (idx)
        IDX_CTRL: begin
          next_r.gain = wdat[CTRL_GAIN];
          next_r.c2r  = wdat[CTRL_C2R];
          next_r.dec  = wdat[CTRL_DEC_HI:CTRL_DEC_LO];
        end
        IDX_ROUTE: begin
          next_r.q_sel = wdat[ROUTE_Q];
          next_r.i_sel = wdat[ROUTE_I];
        end
        IDX_FREQ0:  next_r.freq[7:0]   = wdat;
        IDX_FREQ1:  next_r.freq[15:8]  = wdat;
        IDX_FREQ2:  next_r.freq[23:16] = wdat;
        IDX_FREQ3:  next_r.freq[31:24] = wdat;
        IDX_FREQ4:  next_r.freq[39:32] = wdat;
        IDX_FREQ5:  next_r.freq[47:40] = wdat;
        IDX_PHASE0: next_r.phs = wdat;
        default: begin
        end
      endcase
    end
    // signed add is the same bits as unsigned mod 2^48
    next_r.acc   = FREQ_W'(r.acc + r.freq);
    next_r.phase = FREQ_W'(r.acc + {{(FREQ_W-BYTE_W){r.phs[7]}}, r.phs});
    next_r.stage = map_stage;
    next_r.log2  = map_log2;
    // input routing
    next_r.src_i = r.i_sel ? ADC_B_I : ADC_A_I;
    next_r.src_q = r.q_sel ? ADC_B_I : ADC_A_I;
    // output: complex, or real via fs/4 rotation
    if (r.c2r) begin
      next_r.rot = ddcnc_rot_t'(2'(r.rot + 2'h1));
      case (r.rot)
        ROT_P_I: next_r.out_i = gi;
        ROT_N_Q: next_r.out_i = SMP_W'(~gq + 1'b1);
        ROT_N_I: next_r.out_i = SMP_W'(~gi + 1'b1);
        ROT_P_Q: next_r.out_i = gq;
        default: next_r.out_i = gi;
      endcase
      next_r.out_q = '0;
    end else begin
      next_r.rot   = ROT_P_I;
      next_r.out_i = gi;
      next_r.out_q = gq;
    end
  end

  // state register; all fields clear on reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ACK_O      = r.ack;
  assign DAT_O      = {24'h000000, r.dat};
  assign SRC_I_O    = r.src_i;
  assign SRC_Q_O    = r.src_q;
  assign OUT_I_O    = r.out_i;
  assign OUT_Q_O    = r.out_q;
  assign PHASE_O    = r.phase;
  assign STAGE_EN_O = r.stage;
  assign DEC_LOG2_O = r.log2;
  assign C2R_O      = r.c2r;

  // checks on the register state
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_wr_freq5;
    req && WE_I && r.ack && SEL_I[0] && idx == IDX_FREQ5;
  endsequence

  sequence s_rd_route;
    req && !WE_I && !r.ack && idx == IDX_ROUTE;
  endsequence

  // real mode just switched on, unity gain: rotation starts at +I
  sequence s_c2r_first;
    !r.c2r ##1 (r.c2r && !r.gain);
  endsequence

  a_cplx_ratio_div2: assert property (
    (r.dec == DEC_DIV2 && !r.c2r) |=> r.log2 == 3'h1)
    else $error("complex div2 ratio wrong");

  a_cplx_ratio_div16: assert property (
    (r.dec == DEC_DIV16 && !r.c2r) |=> r.log2 == 3'h4)
    else $error("complex div16 ratio wrong");

  a_cplx_ratio_div4: assert property (
    (r.dec == DEC_DIV4 && !r.c2r) |=> r.log2 == 3'h2)
    else $error("complex div4 ratio wrong");

  a_real_ratio_halved: assert property (
    (r.dec == DEC_DIV8 && r.c2r) |=> r.log2 == 3'h2)
    else $error("real mode ratio not halved");

  a_real_ratio_div1: assert property (
    (r.dec == DEC_DIV2 && r.c2r) |=> r.log2 == 3'h0)
    else $error("real mode div1 ratio wrong");

  a_stage_set_all: assert property (
    (r.dec == DEC_DIV16) |=> r.stage == STG_ALL)
    else $error("div16 must use all stages");

  a_stage_set_final: assert property (
    (r.dec == DEC_DIV2) |=> r.stage == STG_FINAL)
    else $error("div2 must use final stage only");

  a_q_route_b: assert property (
    r.q_sel |=> r.src_q == $past(ADC_B_I))
    else $error("Q path not from channel B");

  a_i_route_a: assert property (
    !r.i_sel |=> r.src_i == $past(ADC_A_I))
    else $error("I path not from channel A");

  a_i_route_b: assert property (
    r.i_sel |=> r.src_i == $past(ADC_B_I))
    else $error("I path not from channel B");

  a_route_reserved: assert property (
    s_rd_route |=> ACK_O && DAT_O[7:3] == 5'h0 && !DAT_O[1])
    else $error("reserved routing bits not zero");

  a_acc_step: assert property (
    ##1 r.acc == FREQ_W'($past(r.acc) + $past(r.freq)))
    else $error("accumulator did not step");

  a_freq_top_byte: assert property (
    s_wr_freq5 |=> r.freq[47:40] == $past(DAT_I[7:0]))
    else $error("byte5 not in bits 47:40");

  a_acc_wrap: assert property (
    (r.freq[FREQ_W-1] && r.acc[FREQ_W-1])
      |=> r.acc < $past(r.acc))
    else $error("accumulator did not wrap");

  a_phase_offset: assert property (
    ##1 r.phase == FREQ_W'($past(r.acc)
      + {{(FREQ_W-BYTE_W){$past(r.phs[7])}}, $past(r.phs)}))
    else $error("phase offset not applied");

  a_real_q_zero: assert property (
    r.c2r |=> OUT_Q_O == '0)
    else $error("Q output not silent in real mode");

  a_real_rot_first: assert property (
    s_c2r_first |=> OUT_I_O == $past(FILT_I_I))
    else $error("real mode rotation not starting at I");

  a_gain_double: assert property (
    (r.gain && !r.c2r) |=> OUT_I_O == SMP_W'($past(FILT_I_I) << 1))
    else $error("gain bit did not double");

  a_gain_unity: assert property (
    (!r.gain && !r.c2r) |=> OUT_I_O == $past(FILT_I_I))
    else $error("unity gain path altered");

  a_reset_clear: assert property (
    $past(RST_I) |-> r.freq == '0 && r.dec == DEC_DIV4 && !r.q_sel && r.phs == '0)
    else $error("fields not zero after reset");
endmodule

// [testbench/ddcnc_top_tb.sv]
/*
  ddcnc_top_tb: self-checking bench for the downconverter channel 0
  configuration block, driven through classic Wishbone tasks.
  Assumes ddcnc_top and ddcnc_pkg compiled first; one 10 MHz clock.
*/
`timescale 1ns/1ps
module ddcnc_top_tb
  import ddcnc_pkg::*;
();
  logic        CLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        CYC_I = 1'b0;
  logic        STB_I = 1'b0;
  logic        WE_I  = 1'b0;
  logic [11:0] ADR_I = 12'h000;
  logic [3:0]  SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0;
  logic [31:0] DAT_O;
  logic        ACK_O;
  logic [15:0] ADC_A_I = 16'h0, ADC_B_I = 16'h0, FILT_I_I = 16'h0, FILT_Q_I = 16'h0;
  logic [15:0] SRC_I_O, SRC_Q_O, OUT_I_O, OUT_Q_O;
  logic [47:0] PHASE_O, p0, p1;
  logic [3:0]  STAGE_EN_O;
  logic [2:0]  DEC_LOG2_O;
  logic        C2R_O;
  logic [7:0]  rd;
  logic [15:0] s [4], e [4];
  logic [9:0]  fidx [6] = '{IDX_FREQ0, IDX_FREQ1, IDX_FREQ2, IDX_FREQ3, IDX_FREQ4, IDX_FREQ5};
  logic [1:0]  codes [4] = '{DEC_DIV2, DEC_DIV4, DEC_DIV8, DEC_DIV16};
  logic [3:0]  stg [4] = '{STG_FINAL, STG_TWO, STG_THREE, STG_ALL};
  logic [7:0]  rt [4] = '{8'h00, 8'h01, 8'h04, 8'h05};
  logic [47:0] fw = 48'h8123_4567_89ab;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #50 CLK_I = ~CLK_I;

  ddcnc_top #(.SMP_W(16)) dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ADC_A_I(ADC_A_I),
    .ADC_B_I(ADC_B_I), .SRC_I_O(SRC_I_O), .SRC_Q_O(SRC_Q_O), .FILT_I_I(FILT_I_I),
    .FILT_Q_I(FILT_Q_I), .OUT_I_O(OUT_I_O), .OUT_Q_O(OUT_Q_O), .PHASE_O(PHASE_O),
    .STAGE_EN_O(STAGE_EN_O), .DEC_LOG2_O(DEC_LOG2_O), .C2R_O(C2R_O)
  );

  // verdict and end of run, shared by main sequence and timeout
  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled, data taken at that edge
  task automatic wb(input logic [9:0] idx, input logic we, input logic [7:0] wd);
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= {idx, 2'b00};
    SEL_I <= 4'h1;
    DAT_I <= {24'h0, wd};
    do @(posedge CLK_I); while (ACK_O !== 1'b1);
    rd = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I  <= 1'b0;
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    check(rd, exp);
  endtask

  // hang guard: a run far beyond the expected few hundred cycles
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge CLK_I);
    RST_I <= 1'b0;
    // reset values, unmapped place included
    rdchk(IDX_CTRL, 8'h00);
    rdchk(IDX_ROUTE, 8'h00);
    rdchk(IDX_PHASE0, 8'h00);
    for (int i = 0; i < 6; i++) rdchk(fidx[i], 8'h00);
    check(STAGE_EN_O, STG_TWO);
    check(DEC_LOG2_O, 48'h2);
    wb(10'h3e0, 1'b1, 8'h5a);
    rdchk(10'h3e0, 8'h00);
    $display("test reset done");
    // every decimation code in complex and in real mode
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        wb(IDX_CTRL, 1'b1, {4'h0, m[0], 1'b0, codes[c]});
        repeat (2) @(posedge CLK_I);
        check(STAGE_EN_O, stg[c]);
        check(DEC_LOG2_O, 48'(c + 1 - m));
        rdchk(IDX_STATUS, {1'b0, 3'(c + 1 - m), stg[c]});
        check(C2R_O, m[0]);
      end
    end
    $display("test decimation done");
    // routing, with reserved bits written as ones
    ADC_A_I <= 16'h1111;
    ADC_B_I <= 16'h2222;
    for (int r = 0; r < 4; r++) begin
      wb(IDX_ROUTE, 1'b1, rt[r] | 8'hfa);
      rdchk(IDX_ROUTE, rt[r]);
      repeat (2) @(posedge CLK_I);
      check(SRC_I_O, rt[r][0] ? 16'h2222 : 16'h1111);
      check(SRC_Q_O, rt[r][2] ? 16'h2222 : 16'h1111);
    end
    $display("test routing done");
    // negative frequency word: byte order and per-cycle increment
    for (int i = 0; i < 6; i++) wb(fidx[i], 1'b1, fw[8*i +: 8]);
    for (int i = 0; i < 6; i++) rdchk(fidx[i], fw[8*i +: 8]);
    @(posedge CLK_I);
    p0 = PHASE_O;
    @(posedge CLK_I);
    p1 = PHASE_O;
    check(p1 - p0, fw);
    // phase offset moves a stopped oscillator by -128
    for (int i = 0; i < 6; i++) wb(fidx[i], 1'b1, 8'h00);
    repeat (3) @(posedge CLK_I);
    p0 = PHASE_O;
    wb(IDX_PHASE0, 1'b1, 8'h80);
    rdchk(IDX_PHASE0, 8'h80);
    p1 = PHASE_O;
    check(p1 - p0, 48'hffff_ffff_ff80);
    $display("test oscillator done");
    // gain doubles both paths, then unity again
    FILT_I_I <= 16'h1234;
    FILT_Q_I <= 16'h0421;
    wb(IDX_CTRL, 1'b1, 8'h40);
    repeat (3) @(posedge CLK_I);
    check(OUT_I_O, 16'h2468);
    check(OUT_Q_O, 16'h0842);
    rdchk(IDX_CTRL, 8'h40);
    wb(IDX_CTRL, 1'b1, 8'h00);
    repeat (3) @(posedge CLK_I);
    check(OUT_I_O, 16'h1234);
    // real output: rotation I, -Q, -I, Q and a silent Q path
    wb(IDX_CTRL, 1'b1, 8'h08);
    // first rotated sample is launched at this edge
    @(posedge CLK_I);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK_I);
      s[i] = OUT_I_O;
    end
    check(OUT_Q_O, 16'h0000);
    e = '{16'h1234, 16'hfbdf, 16'hedcc, 16'h0421};
    for (int j = 0; j < 4; j++) check(s[j], e[j]);
    $display("test output modes done");
    // mid-run reset with live settings must clear control, routing, offset and mode outputs
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    rdchk(IDX_CTRL, 8'h00);
    rdchk(IDX_ROUTE, 8'h00);
    rdchk(IDX_PHASE0, 8'h00);
    check(C2R_O, 1'b0);
    check(STAGE_EN_O, STG_TWO);
    check(DEC_LOG2_O, 48'h2);
    check(SRC_I_O, 16'h1111);
    $display("test second reset done");
    results();
  end
endmodule
